// *** rtl/psv_consts.vh ***
// Purpose: constants for the program supervisor (windowed watchdog)
// Assumes: 32-bit apb, word-aligned registers
// Notes: all offsets are byte addresses
//
// Summary of operation
// - the supervisor runs either in plain timeout mode or in window mode.
// - in timeout mode the counter runs down while the supervisor is on.
// - a missed clear before the period ends asserts the soft reset.
// - window mode accepts a clear only inside a window within the period.
// - in window mode a clear too early or too late asserts the reset.
// - the window opens at a programmable count; earlier clears reset.
// - a warning interrupt is raised before expiry, the reset on expiry or on an early window clear.
// - the period is a 32-bit software value used in both modes.
`ifndef PSV_CONSTS_VH
`define PSV_CONSTS_VH
`define PSV_A_CTRL 12'h000
`define PSV_A_PERIOD 12'h004
`define PSV_A_WINDOW 12'h008
`define PSV_A_WARN 12'h00c
`define PSV_A_KICK 12'h010
`define PSV_A_COUNT 12'h014
`define PSV_A_STAT 12'h018
`define PSV_A_IEN 12'h01c
`define PSV_A_ICLR 12'h020
`define PSV_KICK_KEY 32'h0000_5a5a
`define PSV_B_EN 0
`define PSV_B_WIN 1
`define PSV_B_RSTEN 2
`define PSV_R_PERIOD 32'hffff_ffff
`define PSV_R_WARN 32'h0000_0100
`define PSV_NEV 3
`define PSV_E_WARN 0
`define PSV_E_EXP 1
`define PSV_E_BAD 2
`define PSV_RST_CYC 8'h10
`endif

// *** rtl/psv_sticky.v ***
// Purpose: sticky event bits with enable and write-one clear
// Assumes: events are one-cycle pulses on mclk_in
// Notes: a set in the clear cycle wins
`include "psv_consts.vh"
module psv_sticky (
  input wire mclk_in,
  input wire srst_in,
  input wire [`PSV_NEV-1:0] ev_in,
  input wire [`PSV_NEV-1:0] clr_in,
  input wire [`PSV_NEV-1:0] en_in,
  output wire [`PSV_NEV-1:0] stat_out,
  output reg irq_out
);
  reg [`PSV_NEV-1:0] stat_reg;
  genvar i;
  // one sticky flag per event
  generate
    for (i = 0; i < `PSV_NEV; i = i + 1) begin : g_bit
      always @(posedge mclk_in) begin
        if (srst_in)
          stat_reg[i] <= 1'b0;
        else if (ev_in[i])
          stat_reg[i] <= 1'b1;
        else if (clr_in[i])
          stat_reg[i] <= 1'b0;
      end
    end
  endgenerate
  assign stat_out = stat_reg;
  // level interrupt
  always @(posedge mclk_in) begin
    if (srst_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(stat_reg & en_in);
  end
endmodule // psv_sticky

// *** rtl/psv_pulse.v ***
// Purpose: stretch a reset request into a fixed-length reset pulse
// Assumes: trigger is a one-cycle pulse
// Notes: retriggers are ignored while the pulse runs
`include "psv_consts.vh"
module psv_pulse (
  input wire mclk_in,
  input wire srst_in,
  input wire trig_in,
  output reg rst_out
);
  reg [7:0] cnt_reg;
  // count down the pulse length
  always @(posedge mclk_in) begin
    if (srst_in) begin
      cnt_reg <= 8'h00;
      rst_out <= 1'b0;
    end else if (trig_in && cnt_reg == 8'h00) begin
      cnt_reg <= `PSV_RST_CYC;
      rst_out <= 1'b1;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
      rst_out <= (cnt_reg != 8'h01);
    end
  end
endmodule // psv_pulse

// *** rtl/psv_top.v ***
// Purpose: program supervisor, windowed watchdog with apb registers
// Assumes: single clock mclk_in, synchronous reset srst_in
// Notes: counter runs down; warning irq precedes the soft reset on expiry
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`include "psv_consts.vh"
module psv_top (
  input wire mclk_in,
  input wire srst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  output reg irq_out,
  output reg soft_rst_out
);
  ////////////////////////////////////////////////////////////////////////
  // registers
  reg [2:0] ctrl_reg;
  reg [31:0] period_reg;
  reg [31:0] window_reg;
  reg [31:0] warn_reg;
  reg [31:0] count_reg;
  reg [`PSV_NEV-1:0] ien_reg;
  reg warned_reg;
  reg wr_kick;
  reg wr_clr;
  reg mapped;
  reg [31:0] rd_mux;
  wire setup;
  wire access;
  wire irq_w;
  wire rst_w;
  wire [`PSV_NEV-1:0] stat_w;
  wire [`PSV_NEV-1:0] ev_w;
  wire en;
  wire win_mode;
  wire kick;
  wire early;
  wire expire;
  wire warn_hit;
  wire bad_kick;

  assign en = ctrl_reg[`PSV_B_EN];
  assign win_mode = ctrl_reg[`PSV_B_WIN];

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer in the second access cycle
  assign setup = psel_in && !penable_in;
  assign access = psel_in && penable_in && pready_out;

  // address decode
  always @* begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr_in)
      `PSV_A_CTRL: rd_mux = {29'h0000_0000, ctrl_reg};
      `PSV_A_PERIOD: rd_mux = period_reg;
      `PSV_A_WINDOW: rd_mux = window_reg;
      `PSV_A_WARN: rd_mux = warn_reg;
      `PSV_A_KICK: rd_mux = 32'h0000_0000;
      `PSV_A_COUNT: rd_mux = count_reg;
      `PSV_A_STAT: rd_mux = {29'h0000_0000, stat_w};
      `PSV_A_IEN: rd_mux = {29'h0000_0000, ien_reg};
      `PSV_A_ICLR: rd_mux = 32'h0000_0000;
      default: mapped = 1'b0;
    endcase
  end

  // ready, read data and error
  always @(posedge mclk_in) begin
    if (srst_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (psel_in && penable_in && !pready_out) begin
      pready_out <= 1'b1;
      prdata_out <= pwrite_in ? 32'h0000_0000 : rd_mux;
      pslverr_out <= !mapped;
    end else begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end
  end

  // write strobes
  always @* begin
    wr_kick = access && pwrite_in && paddr_in == `PSV_A_KICK &&
      pwdata_in == `PSV_KICK_KEY;
    wr_clr = access && pwrite_in && paddr_in == `PSV_A_ICLR;
  end

  // configuration registers
  always @(posedge mclk_in) begin
    if (srst_in) begin
      ctrl_reg <= 3'h4;
      period_reg <= `PSV_R_PERIOD;
      window_reg <= 32'h0000_0000;
      warn_reg <= `PSV_R_WARN;
      ien_reg <= 3'h0;
    end else if (access && pwrite_in) begin
      case (paddr_in)
        `PSV_A_CTRL: ctrl_reg <= pwdata_in[2:0];
        `PSV_A_PERIOD: period_reg <= pwdata_in;
        `PSV_A_WINDOW: window_reg <= pwdata_in;
        `PSV_A_WARN: warn_reg <= pwdata_in;
        `PSV_A_IEN: ien_reg <= pwdata_in[2:0];
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // countdown core
  assign kick = wr_kick && en;
  // window opens once the count has fallen to window_reg
  assign early = win_mode && count_reg > window_reg;
  assign bad_kick = kick && early;
  assign expire = en && count_reg == 32'h0000_0000;
  // warning fires before expiry
  assign warn_hit = en && !warned_reg && count_reg == warn_reg &&
    count_reg != 32'h0000_0000;

  // counter and warning state
  always @(posedge mclk_in) begin
    if (srst_in) begin
      count_reg <= `PSV_R_PERIOD;
      warned_reg <= 1'b0;
    end else if (!en || (kick && !early) || expire) begin
      count_reg <= period_reg;
      warned_reg <= 1'b0;
    end else begin
      count_reg <= count_reg - 32'h0000_0001;
      if (warn_hit)
        warned_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // events, status and interrupt
  assign ev_w = {bad_kick, expire, warn_hit};

  // an accepted kick also withdraws a pending warning bit
  psv_sticky u_sticky (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .ev_in(ev_w),
    .clr_in({(wr_clr ? pwdata_in[2:1] : 2'h0),
      ((wr_clr && pwdata_in[`PSV_E_WARN]) || (kick && !early))}),
    .en_in(ien_reg),
    .stat_out(stat_w),
    .irq_out(irq_w)
  );

  // too late in window mode is the expiry itself
  psv_pulse u_pulse (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .trig_in(ctrl_reg[`PSV_B_RSTEN] && (expire || bad_kick)),
    .rst_out(rst_w)
  );

  // registered outputs
  always @(posedge mclk_in) begin
    if (srst_in) begin
      irq_out <= 1'b0;
      soft_rst_out <= 1'b0;
    end else begin
      irq_out <= irq_w;
      soft_rst_out <= rst_w;
    end
  end
endmodule // psv_top

// *** sim/psv_chk.sv ***
// Purpose: port assertions for psv_top
// Assumes: one clock, srst_in synchronous
// Notes: bound to psv_top at the foot
module psv_chk (
  input logic mclk_in,
  input logic srst_in,
  input logic psel_in,
  input logic penable_in,
  input logic pwrite_in,
  input logic [11:0] paddr_in,
  input logic [31:0] pwdata_in,
  input logic [31:0] prdata_out,
  input logic pready_out,
  input logic pslverr_out,
  input logic irq_out,
  input logic soft_rst_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);
  // access cycle still waiting, and interrupt enables cleared
  sequence s_acc;
    psel_in && penable_in && !pready_out;
  endsequence
  sequence s_ien_off;
    pready_out && pwrite_in && paddr_in == 12'h01c && pwdata_in == 0;
  endsequence
  ////////////////////////////////////////
  // bus answer timing and decode
  a_ready_wait: assert property (s_acc |=> pready_out)
    else $error("pready late");
  a_ready_once: assert property (pready_out |=> !pready_out)
    else $error("pready held");
  a_ready_cause: assert property (pready_out |-> $past(penable_in))
    else $error("pready without access");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr alone");
  a_err_zero: assert property (pslverr_out |-> prdata_out == 0)
    else $error("error read not zero");
  a_err_decode: assert property (pready_out && paddr_in[1:0] == 0
    |-> pslverr_out == (paddr_in > 12'h020))
    else $error("address decode wrong");
  // reset pulse and interrupt masking
  a_rst_len: assert property ($rose(soft_rst_out) |->
    soft_rst_out[*8] ##1 soft_rst_out[*8] ##1 !soft_rst_out)
    else $error("reset pulse length");
  a_irq_off: assert property (s_ien_off |-> ##[1:3] !irq_out)
    else $error("irq stays enabled");
endmodule // psv_chk
bind psv_top psv_chk i_psv_chk (.mclk_in, .srst_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
  .irq_out, .soft_rst_out);

// *** sim/tb_top.sv ***
// Purpose: self-checking bench for psv_top
// Assumes: apb slave with one wait state
// Notes: small periods keep the run short
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 0, srst_in = 1, psel_in = 0, penable_in = 0;
  logic pwrite_in = 0, err, pready_out, pslverr_out, irq_out, soft_rst_out;
  logic [11:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, prdata_out, rd, sd = 32'h710e;
  logic [31:0] mdl [0:8] = '{32'h4, '1, 0, 32'h100, 0, '1, 0, 0, 0};
  int error_cnt = 0, compares = 0, cyc = 0, nrst = 0;
  always #2 mclk_in = ~mclk_in;
  psv_top i_psv_top (.mclk_in, .srst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .irq_out,
    .soft_rst_out);
  // reset pulse count and hang limit
  always @(posedge mclk_in) begin
    cyc++;
    if ($rose(soft_rst_out)) nrst++;
    if (cyc == 5000) begin
      error_cnt++;
      test_done();
    end
  end
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    sd ^= sd << 13;
    sd ^= sd >> 17;
    sd ^= sd << 5;
    return sd;
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready; model tracks rw registers
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n = 0;
    @(posedge mclk_in);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready_out !== 1 && n < 20);
    if (n == 20) error_cnt++;
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
    if (w && (a < 12'h010 || a == 12'h01c)) mdl[a[5:2]] = d;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task automatic rdm(input logic [11:0] a);
    apb(0, a, 0);
    chk(rd, mdl[a[5:2]]);
  endtask
  task automatic wsig(ref logic s, input int n);
    for (int i = 0; i < n && s !== 1; i++) @(posedge mclk_in);
  endtask
  task automatic test_done();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // test sequence
  initial begin
    logic [31:0] d;
    repeat (6) @(posedge mclk_in);
    srst_in <= 0;
    for (int i = 0; i < 8; i++) if (i != 4) rdm(12'(4 * i));
    apb(0, 12'h024, 0);
    chk(err, 1);
    chk(rd, 0);
    $display("reset values and decode done");
    wr(12'h004, 32'h28);
    wr(12'h00c, 32'h14);
    wr(12'h01c, 32'h7);
    wr(12'h000, 32'h5);
    apb(0, 12'h014, 0);
    chk(rd < 32'h28, 1);
    wsig(irq_out, 60);
    chk(irq_out, 1);
    chk(soft_rst_out, 0);
    wsig(soft_rst_out, 60);
    chk(soft_rst_out, 1);
    apb(0, 12'h018, 0);
    chk(rd, 32'h3);
    wr(12'h000, 32'h4);
    wr(12'h01c, 32'h0);
    repeat (3) @(posedge mclk_in);
    chk(irq_out, 0);
    wr(12'h020, 32'h7);
    mdl[5] = mdl[1];
    rdm(12'h014);
    $display("timeout mode done");
    wr(12'h004, 32'h3c);
    wr(12'h000, 32'h5);
    d = nrst;
    repeat (6) begin
      repeat (20) @(posedge mclk_in);
      wr(12'h010, 32'h5a5a);
    end
    apb(0, 12'h018, 0);
    chk(rd, 0);
    chk(nrst, d);
    d = rnd();
    if (d == 32'h5a5a) d = 0;
    wr(12'h010, d);
    wsig(soft_rst_out, 80);
    chk(soft_rst_out, 1);
    $display("kick test done");
    wr(12'h000, 32'h4);
    wr(12'h020, 32'h7);
    wr(12'h004, 32'h64);
    wr(12'h008, 32'h1e);
    wr(12'h000, 32'h7);
    wr(12'h010, 32'h5a5a);
    wsig(soft_rst_out, 8);
    chk(soft_rst_out, 1);
    apb(0, 12'h018, 0);
    chk(rd, 32'h4);
    wr(12'h000, 32'h4);
    wr(12'h020, 32'h7);
    wr(12'h000, 32'h7);
    repeat (72) @(posedge mclk_in);
    d = nrst;
    wr(12'h010, 32'h5a5a);
    apb(0, 12'h014, 0);
    chk(rd > 32'h5a, 1);
    apb(0, 12'h018, 0);
    chk(rd, 0);
    chk(nrst, d);
    $display("window mode done");
    test_done();
  end
endmodule // tb_top
